/* src/hdlc_signaling_common_config.sv */
// signaling controller common configuration: registers, irq pin, fill and counts
//
// Overview of operation
// - interrupt pin is open drain whenever the low stage select bit is 0.
// - low select 1 gives push-pull; high select picks active low or high.
// - shared flag: one flag closes a frame and opens the next.
// - in message mode, style bit picks 10-byte packets or continuous reception.
// - datalink fifo access sends fifo bits; software clears external pin enable.
// - timeslot signaling enable gates signaling in selected timeslots 0 to 31.
// - threshold picks block size 32, 16, 4 or 2 bytes; resets to 32.
// - byte count after pool full gives whole frame length unless a receive complete command cleared its low bits.
// - receive complete command clears count low bits matching the threshold.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "hdlc_sig_consts.svh"

module hdlc_signaling_common_config #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // interrupt
  output logic o_irq,
  output logic o_irq_pin_out,
  output logic o_irq_pin_oe,
  // transmit frame source
  input wire logic i_tx_frame_req,
  input wire logic i_tx_bit,
  input wire logic i_tx_last,
  output logic o_tx_take,
  output logic o_tx_line,
  // datalink
  input wire logic i_dl_pin_bit,
  input wire logic i_external_datalink_pin_enable,
  output logic o_dl_bit,
  output logic o_dl_from_fifo,
  // timeslot signaling
  input wire logic i_ts_selected,
  output logic o_ts_signaling_active,
  // receive path
  input wire logic i_bit_oriented_message,
  input wire logic i_rx_byte_valid,
  input wire logic i_rx_frame_end,
  output logic o_bom_continuous
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] irq_pin_cfg_q;
  logic [7:0] sig_cfg_one_q;
  logic [`IRQ_BITS-1:0] irq_status_q;
  logic [`IRQ_BITS-1:0] irq_mask_q;
  logic rx_done_cmd_q;

  logic setup;
  logic wr_en;
  logic [`IRQ_BITS-1:0] irq_event;
  logic [CNT_W-1:0] rx_count;
  logic pool_full;
  logic bom_packet;
  logic tx_frame_done;
  logic irq_level;

  logic irq_stage_select_low;
  logic irq_stage_select_high;
  logic shared_flag_enable;
  logic message_receive_style;
  logic datalink_fifo_access_enable;
  logic timeslot_signaling_enable;
  logic idle_fill_select;
  logic [1:0] rx_threshold;

  assign irq_stage_select_low = irq_pin_cfg_q[`IRQ_SEL_LOW_BIT];
  assign irq_stage_select_high = irq_pin_cfg_q[`IRQ_SEL_HIGH_BIT];
  assign shared_flag_enable = sig_cfg_one_q[`CFG_SHARED_FLAG_BIT];
  assign message_receive_style = sig_cfg_one_q[`CFG_RX_STYLE_BIT];
  assign datalink_fifo_access_enable = sig_cfg_one_q[`CFG_DL_FIFO_BIT];
  assign timeslot_signaling_enable = sig_cfg_one_q[`CFG_TS_SIG_BIT];
  assign idle_fill_select = sig_cfg_one_q[`CFG_IDLE_FILL_BIT];
  assign rx_threshold = {sig_cfg_one_q[`CFG_THR_HIGH_BIT], sig_cfg_one_q[`CFG_THR_LOW_BIT]};

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  function automatic logic addr_known(input logic [7:0] addr);
    unique case (addr)
      `ADDR_IRQ_PIN_CFG,
      `ADDR_SIG_CFG_ONE,
      `ADDR_IRQ_STATUS,
      `ADDR_IRQ_MASK,
      `ADDR_COMMAND,
      `ADDR_RX_COUNT_LOW,
      `ADDR_RX_COUNT_HIGH: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // answer one cycle after setup, so pready and read data are both flops
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !addr_known(i_paddr);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
    end else if (setup && !i_pwrite) begin
      unique case (i_paddr)
        `ADDR_IRQ_PIN_CFG: o_prdata <= {24'h0, irq_pin_cfg_q};
        `ADDR_SIG_CFG_ONE: o_prdata <= {24'h0, sig_cfg_one_q};
        `ADDR_IRQ_STATUS: o_prdata <= {28'h0, irq_status_q};
        `ADDR_IRQ_MASK: o_prdata <= {28'h0, irq_mask_q};
        `ADDR_RX_COUNT_LOW: o_prdata <= {24'h0, rx_count[7:0]};
        `ADDR_RX_COUNT_HIGH: o_prdata <= 32'(rx_count[CNT_W-1:8]);
        default: o_prdata <= 32'h0;
      endcase
    end else begin
      o_prdata <= 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_pin_cfg_q <= `RST_IRQ_PIN_CFG;
    end else if (wr_en && i_paddr == `ADDR_IRQ_PIN_CFG) begin
      irq_pin_cfg_q <= i_pwdata[7:0] & `IRQ_PIN_WRITABLE;
    end
  end

  // threshold may be written at any time; keeping to the idle or
  // between-blocks window is software's job, the count then stays exact
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sig_cfg_one_q <= `RST_SIG_CFG_ONE;
    end else if (wr_en && i_paddr == `ADDR_SIG_CFG_ONE) begin
      sig_cfg_one_q <= i_pwdata[7:0] & `CFG_WRITABLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      irq_mask_q <= `RST_IRQ_MASK;
    end else if (wr_en && i_paddr == `ADDR_IRQ_MASK) begin
      irq_mask_q <= i_pwdata[`IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rx_done_cmd_q <= 1'b0;
    end else begin
      rx_done_cmd_q <= wr_en && i_paddr == `ADDR_COMMAND && i_pwdata[`CMD_RX_DONE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  assign irq_event[`IRQ_POOL_FULL] = pool_full;
  assign irq_event[`IRQ_RX_FRAME_END] = i_rx_frame_end;
  assign irq_event[`IRQ_BOM_PACKET] = bom_packet;
  assign irq_event[`IRQ_TX_FRAME_DONE] = tx_frame_done;

  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_BITS; gi++) begin : g_status
      // a new event wins over a write-one clear in the same cycle
      always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
          irq_status_q[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_status_q[gi] <= 1'b1;
        end else if (wr_en && i_paddr == `ADDR_IRQ_STATUS && i_pwdata[gi]) begin
          irq_status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_level = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // interrupt pin stage
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_irq_pin_out <= 1'b0;
      o_irq_pin_oe <= 1'b0;
    end else begin
      o_irq <= irq_level;
      if (!irq_stage_select_low) begin
        // open drain only pulls low, the high select is ignored
        o_irq_pin_out <= 1'b0;
        o_irq_pin_oe <= irq_level;
      end else begin
        o_irq_pin_oe <= 1'b1;
        o_irq_pin_out <= irq_stage_select_high ? irq_level : !irq_level;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------
  hdlc_tx_fill u_tx_fill (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_shared_flag_enable(shared_flag_enable),
    .i_idle_fill_select(idle_fill_select),
    .i_tx_frame_req(i_tx_frame_req),
    .i_tx_bit(i_tx_bit),
    .i_tx_last(i_tx_last),
    .o_tx_take(o_tx_take),
    .o_tx_line(o_tx_line),
    .o_tx_frame_done(tx_frame_done)
  );

  // ----------------------------------------------------------------
  // datalink and timeslot signaling
  // ----------------------------------------------------------------
  // with the external pin still enabled the pin wins, so fifo bits never
  // reach the line until software clears it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_dl_bit <= 1'b1;
      o_dl_from_fifo <= 1'b0;
    end else begin
      o_dl_from_fifo <= datalink_fifo_access_enable && !i_external_datalink_pin_enable;
      if (datalink_fifo_access_enable && !i_external_datalink_pin_enable) begin
        o_dl_bit <= o_tx_line;
      end else begin
        o_dl_bit <= i_dl_pin_bit;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ts_signaling_active <= 1'b0;
    end else begin
      o_ts_signaling_active <= timeslot_signaling_enable && i_ts_selected;
    end
  end

  // ----------------------------------------------------------------
  // receive counting
  // ----------------------------------------------------------------
  hdlc_rx_count #(
    .CNT_W(CNT_W)
  ) u_rx_count (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_threshold(rx_threshold),
    .i_bom_mode(i_bit_oriented_message),
    .i_message_receive_style(message_receive_style),
    .i_rx_done_cmd(rx_done_cmd_q),
    .i_rx_byte_valid(i_rx_byte_valid),
    .i_rx_frame_end(i_rx_frame_end),
    .o_rx_count(rx_count),
    .o_pool_full(pool_full),
    .o_bom_packet(bom_packet)
  );

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_bom_continuous <= 1'b0;
    end else begin
      o_bom_continuous <= i_bit_oriented_message && message_receive_style;
    end
  end

endmodule

/* src/hdlc_sig_consts.svh */
// constants for the signaling common configuration block
`ifndef HDLC_SIG_CONSTS_SVH
`define HDLC_SIG_CONSTS_SVH

// register word index, byte address is four times the index
`define IDX_IRQ_PIN_CFG 8'h08
`define IDX_SIG_CFG_ONE 8'h09
`define ADDR_IRQ_PIN_CFG 8'h20
`define ADDR_SIG_CFG_ONE 8'h24
`define ADDR_IRQ_STATUS 8'h40
`define ADDR_IRQ_MASK 8'h44
`define ADDR_COMMAND 8'h48
`define ADDR_RX_COUNT_LOW 8'h4c
`define ADDR_RX_COUNT_HIGH 8'h50

// reset values
`define RST_IRQ_PIN_CFG 8'h00
`define RST_SIG_CFG_ONE 8'h00
`define RST_IRQ_MASK 4'h0

// field positions
`define IRQ_SEL_LOW_BIT 0
`define IRQ_SEL_HIGH_BIT 1
`define CFG_SHARED_FLAG_BIT 7
`define CFG_RX_STYLE_BIT 6
`define CFG_DL_FIFO_BIT 5
`define CFG_TS_SIG_BIT 4
`define CFG_IDLE_FILL_BIT 3
`define CFG_THR_HIGH_BIT 1
`define CFG_THR_LOW_BIT 0
`define CFG_WRITABLE 8'hfb
`define IRQ_PIN_WRITABLE 8'h03
`define CMD_RX_DONE_BIT 0

// interrupt status bits
`define IRQ_BITS 4
`define IRQ_POOL_FULL 0
`define IRQ_RX_FRAME_END 1
`define IRQ_BOM_PACKET 2
`define IRQ_TX_FRAME_DONE 3

// line constants
`define FLAG_PATTERN 8'h7e
`define BIT_CNT_LAST 3'h7
`define BOM_PACKET_LEN 4'ha
`define THR_MASK_32 5'h1f
`define THR_MASK_16 5'h0f
`define THR_MASK_4 5'h03
`define THR_MASK_2 5'h01

`endif

/* src/hdlc_sig_pkg.sv */
// types shared by the signaling common configuration block
package hdlc_sig_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_OPEN = 2'b01,
    TX_DATA = 2'b10,
    TX_CLOSE = 2'b11
  } tx_state_t;

  typedef enum logic [1:0] {
    THR_32 = 2'b00,
    THR_16 = 2'b01,
    THR_4 = 2'b10,
    THR_2 = 2'b11
  } rx_threshold_t;

endpackage

/* src/hdlc_tx_fill.sv */
// transmit bit sequencer: flags, frame data and interframe fill
`timescale 1ns/100ps
`include "hdlc_sig_consts.svh"

module hdlc_tx_fill (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // configuration
  input wire logic i_shared_flag_enable,
  input wire logic i_idle_fill_select,
  // frame source
  input wire logic i_tx_frame_req,
  input wire logic i_tx_bit,
  input wire logic i_tx_last,
  output logic o_tx_take,
  // line side
  output logic o_tx_line,
  output logic o_tx_frame_done
);

  hdlc_sig_pkg::tx_state_t state_q, state_d;
  logic [2:0] cnt_q;
  logic [7:0] flag;
  logic byte_end;

  assign flag = `FLAG_PATTERN;
  assign byte_end = (cnt_q == `BIT_CNT_LAST);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      hdlc_sig_pkg::TX_IDLE: begin
        // a frame starts only on a byte boundary of the fill
        if (i_tx_frame_req && byte_end) begin
          state_d = hdlc_sig_pkg::TX_OPEN;
        end
      end
      hdlc_sig_pkg::TX_OPEN: begin
        if (byte_end) begin
          state_d = hdlc_sig_pkg::TX_DATA;
        end
      end
      hdlc_sig_pkg::TX_DATA: begin
        if (i_tx_last) begin
          state_d = hdlc_sig_pkg::TX_CLOSE;
        end
      end
      hdlc_sig_pkg::TX_CLOSE: begin
        if (byte_end) begin
          if (i_tx_frame_req && i_shared_flag_enable) begin
            state_d = hdlc_sig_pkg::TX_DATA;
          end else if (i_tx_frame_req) begin
            state_d = hdlc_sig_pkg::TX_OPEN;
          end else begin
            state_d = hdlc_sig_pkg::TX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= hdlc_sig_pkg::TX_IDLE;
      cnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == hdlc_sig_pkg::TX_DATA) ? 3'h0 : cnt_q + 3'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_tx_line <= 1'b1;
    end else begin
      unique case (state_q)
        hdlc_sig_pkg::TX_IDLE: o_tx_line <= i_idle_fill_select ? flag[cnt_q] : 1'b1;
        hdlc_sig_pkg::TX_DATA: o_tx_line <= i_tx_bit;
        default: o_tx_line <= flag[cnt_q];
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_tx_take <= 1'b0;
      o_tx_frame_done <= 1'b0;
    end else begin
      o_tx_take <= (state_d == hdlc_sig_pkg::TX_DATA);
      o_tx_frame_done <= (state_q == hdlc_sig_pkg::TX_CLOSE) && byte_end;
    end
  end

endmodule

/* src/hdlc_rx_count.sv */
// receive byte counter with threshold blocks and message packets
`timescale 1ns/100ps
`include "hdlc_sig_consts.svh"

module hdlc_rx_count #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // configuration
  input wire logic [1:0] i_threshold,
  input wire logic i_bom_mode,
  input wire logic i_message_receive_style,
  input wire logic i_rx_done_cmd,
  // received bytes
  input wire logic i_rx_byte_valid,
  input wire logic i_rx_frame_end,
  // results
  output logic [CNT_W-1:0] o_rx_count,
  output logic o_pool_full,
  output logic o_bom_packet
);

  logic [4:0] blk_q;
  logic [3:0] pkt_q;
  logic fresh_q;
  logic [4:0] mask;
  logic [CNT_W-1:0] cleared;

  function automatic logic [4:0] thr_mask(input logic [1:0] thr);
    unique case (hdlc_sig_pkg::rx_threshold_t'(thr))
      hdlc_sig_pkg::THR_32: thr_mask = `THR_MASK_32;
      hdlc_sig_pkg::THR_16: thr_mask = `THR_MASK_16;
      hdlc_sig_pkg::THR_4: thr_mask = `THR_MASK_4;
      hdlc_sig_pkg::THR_2: thr_mask = `THR_MASK_2;
    endcase
  endfunction

  assign mask = thr_mask(i_threshold);
  // the complete command must not be lost when a byte or frame end lands in its cycle
  assign cleared = i_rx_done_cmd ? (o_rx_count & ~CNT_W'(mask)) : o_rx_count;

  // count holds the frame length less any low bits the complete command cleared, blocks only gate the pool event
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rx_count <= '0;
      fresh_q <= 1'b1;
    end else if (i_rx_byte_valid) begin
      o_rx_count <= fresh_q ? CNT_W'(1) : cleared + CNT_W'(1);
      fresh_q <= 1'b0;
    end else if (i_rx_frame_end) begin
      o_rx_count <= cleared;
      fresh_q <= 1'b1;
    end else begin
      o_rx_count <= cleared;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      blk_q <= 5'h0;
      o_pool_full <= 1'b0;
    end else begin
      o_pool_full <= 1'b0;
      if (i_rx_byte_valid) begin
        // a raised threshold mid-block stretches the block to the new size
        if (blk_q >= mask) begin
          blk_q <= 5'h0;
          o_pool_full <= 1'b1;
        end else begin
          blk_q <= blk_q + 5'h1;
        end
      end else if (i_rx_frame_end) begin
        blk_q <= 5'h0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pkt_q <= 4'h0;
      o_bom_packet <= 1'b0;
    end else begin
      o_bom_packet <= 1'b0;
      if (!i_bom_mode || i_message_receive_style) begin
        pkt_q <= 4'h0;
      end else if (i_rx_byte_valid) begin
        if (pkt_q == `BOM_PACKET_LEN - 4'h1) begin
          pkt_q <= 4'h0;
          o_bom_packet <= 1'b1;
        end else begin
          pkt_q <= pkt_q + 4'h1;
        end
      end
    end
  end

endmodule

/* verification/hdlc_sig_line_model.sv */
// frame source model standing in for the line data path
`timescale 1ns/100ps
module hdlc_sig_line_model (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // bench control
  input wire logic i_go,
  // toward the block
  input wire logic i_take,
  output logic o_req,
  output logic o_bit,
  output logic o_last
);
  localparam logic [7:0] frame_bits = 8'h96;
  logic [2:0] idx_q;
  logic busy_q;
  // a frame in flight keeps its request up after i_go drops, so frames always end whole
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      idx_q <= 3'h0;
      busy_q <= 1'b0;
    end else if (i_take) begin
      idx_q <= idx_q + 3'h1;
      busy_q <= (idx_q != 3'h7);
    end
  end
  assign o_req = i_go | busy_q;
  assign o_bit = frame_bits[idx_q];
  assign o_last = (idx_q == 3'h7);
endmodule

/* verification/hdlc_sig_checker.sv */
// assertion checker for the signaling common configuration block
`timescale 1ns/100ps
module hdlc_sig_checker (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // pins
  input wire logic o_irq,
  input wire logic o_irq_pin_out,
  input wire logic o_irq_pin_oe,
  input wire logic o_tx_take,
  input wire logic i_dl_pin_bit,
  input wire logic i_external_datalink_pin_enable,
  input wire logic o_dl_bit,
  input wire logic o_dl_from_fifo,
  input wire logic i_ts_selected,
  input wire logic o_ts_signaling_active,
  input wire logic i_bit_oriented_message,
  input wire logic o_bom_continuous
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_pready_after_setup: assert property (i_psel && !i_penable |=> o_pready) else $error("pready late");
  a_pready_one_cycle: assert property (o_pready |=> !o_pready) else $error("pready too long");
  a_slverr_with_ready: assert property (o_pslverr |-> o_pready) else $error("pslverr alone");
  a_rdata_quiet_idle: assert property (!o_pready |-> o_prdata == 32'h0) else $error("prdata not zero");
  a_odrain_released: assert property (!o_irq_pin_oe |-> !o_irq_pin_out) else $error("pin out high");
  a_ts_gate_sel: assert property (o_ts_signaling_active |-> $past(i_ts_selected)) else $error("ts gate");
  a_bom_style_gate: assert property (o_bom_continuous |-> $past(i_bit_oriented_message)) else $error("bom");
  a_dl_fifo_gate: assert property (o_dl_from_fifo |-> !$past(i_external_datalink_pin_enable)) else $error("dl");
  a_dl_pin_path: assert property (!$past(i_rst) && $past(i_external_datalink_pin_enable)
    |-> o_dl_bit == $past(i_dl_pin_bit)) else $error("dl pin path");
  c_slverr: cover property (o_pslverr);
  c_tx_data: cover property (o_tx_take);
  c_irq_high: cover property (o_irq && o_irq_pin_out);
  c_dl_fifo: cover property (o_dl_from_fifo);
endmodule
bind hdlc_signaling_common_config hdlc_sig_checker chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_psel(i_psel), .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_irq(o_irq), .o_irq_pin_out(o_irq_pin_out), .o_irq_pin_oe(o_irq_pin_oe), .o_tx_take(o_tx_take),
  .i_dl_pin_bit(i_dl_pin_bit), .i_external_datalink_pin_enable(i_external_datalink_pin_enable),
  .o_dl_bit(o_dl_bit), .o_dl_from_fifo(o_dl_from_fifo), .i_ts_selected(i_ts_selected),
  .o_ts_signaling_active(o_ts_signaling_active), .i_bit_oriented_message(i_bit_oriented_message),
  .o_bom_continuous(o_bom_continuous));

/* verification/testbench.sv */
// self-checking testbench for the signaling common configuration block
`timescale 1ns/100ps
module testbench;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, pin_out, pin_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic req, tbit, tlast, take, line, dl_pin, ext_en, dl_bit, dl_fifo;
  logic ts_sel, ts_act, bit_oriented_message, bv, fe, bom_cont, go, e;
  int failures, checked;
  hdlc_signaling_common_config dut_u (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_irq(irq), .o_irq_pin_out(pin_out), .o_irq_pin_oe(pin_oe), .i_tx_frame_req(req),
    .i_tx_bit(tbit), .i_tx_last(tlast), .o_tx_take(take), .o_tx_line(line), .i_dl_pin_bit(dl_pin),
    .i_external_datalink_pin_enable(ext_en), .o_dl_bit(dl_bit), .o_dl_from_fifo(dl_fifo),
    .i_ts_selected(ts_sel), .o_ts_signaling_active(ts_act), .i_bit_oriented_message(bit_oriented_message),
    .i_rx_byte_valid(bv), .i_rx_frame_end(fe), .o_bom_continuous(bom_cont));
  hdlc_sig_line_model line_u (.i_sys_clk(clk), .i_rst(rst), .i_go(go), .i_take(take), .o_req(req),
    .o_bit(tbit), .o_last(tlast));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  // the pin bit toggles every cycle so a stale path cannot pass
  always @(posedge clk) dl_pin <= ~dl_pin;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // no wait count is assumed here, the watchdog ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic bytes(input int n);
    repeat (n) begin
      @(posedge clk);
      bv <= 1;
      @(posedge clk);
      bv <= 0;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic fend;
    @(posedge clk);
    fe <= 1;
    @(posedge clk);
    fe <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic pin_chk(input logic [1:0] m, input logic [1:0] exp);
    wr(8'h20, {30'h0, m});
    repeat (3) @(posedge clk);
    check({pin_oe, pin_out}, exp);
  endtask
  task automatic gap(output int g);
    int n;
    g = 0;
    n = 0;
    while (take !== 1'b1 && n < 300) begin @(posedge clk); n++; end
    while (take === 1'b1 && n < 300) begin @(posedge clk); n++; end
    while (take !== 1'b1 && n < 300) begin @(posedge clk); g++; n++; end
  endtask
  task automatic scan(output int flags, output int ones, output int dlbad);
    logic [7:0] sh;
    logic prev;
    flags = 0;
    ones = 0;
    dlbad = 0;
    sh = 8'h00;
    @(posedge clk);
    prev = line;
    for (int k = 1; k < 32; k++) begin
      @(posedge clk);
      if (dl_bit !== prev) dlbad++;
      prev = line;
      if (line === 1'b1) ones++;
      sh = {line, sh[7:1]};
      if (k >= 8 && sh === 8'h7e) flags++;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    apb(0, 8'h24, 0); check(r, 32'h0);
    apb(0, 8'h20, 0); check(r, 32'h0);
    apb(0, 8'h44, 0); check(r, 32'h0);
    apb(0, 8'h7c, 0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    wr(8'h24, 32'hff); apb(0, 8'h24, 0); check(r, 32'hfb);
    wr(8'h20, 32'hff); apb(0, 8'h20, 0); check(r, 32'h3);
    wr(8'h4c, 32'hff); apb(0, 8'h4c, 0); check(r, 32'h0);
    ts_sel <= 1;
    bit_oriented_message <= 1;
    repeat (3) @(posedge clk);
    check({ts_act, bom_cont}, 2'b11);
    wr(8'h24, 32'haf);
    repeat (3) @(posedge clk);
    check({ts_act, bom_cont}, 2'b00);
    bit_oriented_message <= 0;
    ext_en <= 0;
  endtask
  task automatic t_count;
    int sz[4] = '{32, 16, 4, 2};
    for (int k = 0; k < 4; k++) begin
      wr(8'h24, k);
      wr(8'h40, 32'hf);
      bytes(sz[k] - 1);
      apb(0, 8'h40, 0); check(r & 32'h1, 0);
      bytes(1);
      apb(0, 8'h40, 0); check(r & 32'h1, 1);
      bytes(3);
      apb(0, 8'h4c, 0); check(r, sz[k] + 3);
      wr(8'h48, 32'h1);
      repeat (3) @(posedge clk);
      apb(0, 8'h4c, 0); check(r, (sz[k] + 3) & ~(sz[k] - 1));
      apb(0, 8'h50, 0); check(r, 32'h0);
      fend;
    end
  endtask
  task automatic t_irq;
    wr(8'h24, 32'h3);
    wr(8'h40, 32'hf);
    wr(8'h44, 32'h1);
    bytes(2);
    fend;
    check(irq, 1);
    pin_chk(2'b00, 2'b10);
    pin_chk(2'b10, 2'b10);
    pin_chk(2'b01, 2'b10);
    pin_chk(2'b11, 2'b11);
    wr(8'h44, 32'h0);
    repeat (3) @(posedge clk);
    check(irq, 0);
    pin_chk(2'b01, 2'b11);
    pin_chk(2'b00, 2'b00);
    wr(8'h44, 32'h1);
    repeat (3) @(posedge clk);
    check(irq, 1);
    wr(8'h40, 32'h1);
    repeat (3) @(posedge clk);
    check(irq, 0);
    apb(0, 8'h40, 0); check(r & 32'h1, 0);
  endtask
  task automatic t_bom;
    wr(8'h24, 32'h0);
    wr(8'h40, 32'hf);
    bit_oriented_message <= 1;
    bytes(9);
    apb(0, 8'h40, 0); check(r & 32'h4, 0);
    bytes(1);
    apb(0, 8'h40, 0); check(r & 32'h4, 4);
    fend;
    wr(8'h24, 32'h40);
    wr(8'h40, 32'hf);
    bytes(10);
    apb(0, 8'h40, 0); check(r & 32'h4, 0);
    fend;
    bit_oriented_message <= 0;
  endtask
  task automatic t_tx;
    int fl, on, bad, g;
    wr(8'h24, 32'h20);
    scan(fl, on, bad);
    check(on, 31);
    check({dl_fifo, 8'(bad)}, 9'h100);
    wr(8'h24, 32'h28);
    scan(fl, on, bad);
    check(fl, 3);
    wr(8'h24, 32'ha8);
    go <= 1;
    gap(g);
    check(g, 8);
    go <= 0;
    repeat (40) @(posedge clk);
    wr(8'h24, 32'h28);
    go <= 1;
    gap(g);
    check(g, 16);
    go <= 0;
    repeat (40) @(posedge clk);
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
  initial begin
    failures = 0;
    checked = 0;
    rst = 1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {dl_pin, ts_sel, bit_oriented_message, bv, fe, go} = '0;
    ext_en = 1;
    repeat (16) @(posedge clk);
    rst <= 0;
    t_regs;
    t_count;
    t_irq;
    t_bom;
    t_tx;
    give_verdict;
  end
endmodule
